// >>> hw/crs_top.sv
`default_nettype none
module crs_top import crs_pkg::*; (
  input  wire logic              clk,               // core clock, 250 MHz
  input  wire logic              rst,               // async reset, active high
  input  wire logic [ADDR_W-1:0] s_awaddr,          // axi write address
  input  wire logic [2:0]        s_awprot,          // axi write protection, unused
  input  wire logic              s_awvalid,         // axi write address valid
  output logic                   s_awready,         // axi write address ready
  input  wire logic [31:0]       s_wdata,           // axi write data
  input  wire logic [3:0]        s_wstrb,           // axi byte strobes
  input  wire logic              s_wvalid,          // axi write data valid
  output logic                   s_wready,          // axi write data ready
  output logic [1:0]             s_bresp,           // axi write response
  output logic                   s_bvalid,          // axi write response valid
  input  wire logic              s_bready,          // axi write response ready
  input  wire logic [ADDR_W-1:0] s_araddr,          // axi read address
  input  wire logic [2:0]        s_arprot,          // axi read protection, unused
  input  wire logic              s_arvalid,         // axi read address valid
  output logic                   s_arready,         // axi read address ready
  output logic [31:0]            s_rdata,           // axi read data
  output logic [1:0]             s_rresp,           // axi read response
  output logic                   s_rvalid,          // axi read data valid
  input  wire logic              s_rready,          // axi read data ready
  input  wire logic              core_wr_en,        // execution unit register write
  input  wire logic [4:0]        core_wr_idx,       // register index to write
  input  wire logic [31:0]       core_wr_data,      // write data, same layout as bus
  input  wire logic [3:0]        core_wr_strb,      // byte enables
  input  wire logic              alu_valid,         // alu result to latch into flags
  input  wire logic [15:0]       alu_result,        // alu result word
  input  wire logic              alu_carry,         // carry, borrow or shifted-out bit
  input  wire logic              alu_overflow,      // signed overflow
  input  wire logic              instr_done,        // instruction completed
  input  wire logic              ack_valid,         // interrupt acknowledged
  input  wire logic              ack_hw,            // acknowledged one is a hardware interrupt
  input  wire logic              ack_single_step,   // acknowledged one is single step
  input  wire logic              swint_exec,        // software interrupt instruction executes
  input  wire logic [5:0]        swint_num,         // its number
  input  wire logic              req_valid,         // maskable interrupt request
  input  wire logic [2:0]        req_prio,          // its priority
  output logic [19:0]            pc_out,            // program counter
  output logic [19:0]            vector_base_out,   // vector table base
  output logic [15:0]            flag_out,          // flag word
  output logic [15:0]            active_sp_out,     // stack pointer picked by stack select
  output logic [15:0]            static_base_out,   // static base
  output logic [15:0]            frame_base_out,    // frame base of active bank
  output logic [31:0]            data_pair_even,    // data 2 high, data 0 low
  output logic [31:0]            data_pair_odd,     // data 3 high, data 1 low
  output logic [31:0]            addr_pair,         // addr 1 high, addr 0 low
  output logic                   single_step_req,   // single step interrupt raised
  output logic                   irq_accept         // request passes enable and priority
);
  typedef struct packed {
    logic [19:0]       pc;                          // program counter
    logic [19:0]       vtab;                        // vector table base
    logic [15:0]       ustk;                        // user stack pointer
    logic [15:0]       istk;                        // interrupt stack pointer
    logic [15:0]       stat;                        // static base
    logic [15:0]       flag;                        // flag word
    logic [15:0]       sp;                          // active stack pointer copy
    logic              aw_have;                     // write address held
    logic [ADDR_W-1:0] aw_addr;                     // held write address
    logic              w_have;                      // write data held
    logic [31:0]       w_data;                      // held write data
    logic [3:0]        w_strb;                      // held strobes
    logic              awready;                     // channel readies
    logic              wready;
    logic              bvalid;                      // write response pending
    logic [1:0]        bresp;
    logic              ar_pend;                     // read address taken, data next
    logic [ADDR_W-1:0] ar_addr;                     // held read address
    logic              arready;
    logic              rvalid;                      // read data pending
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              step_req;                    // single step output
    logic              irq_acc;                     // accept output
  } crs_state_t;

  crs_state_t s_q, s_d;

  logic [NBANKREG-1:0]        mem_wen;              // banked register write enables
  logic [2*NBANKREG-1:0]      mem_wbe;              // banked register byte enables
  logic [DATA_W*NBANKREG-1:0] mem_wdata;            // banked register write data
  logic [DATA_W*NBANKREG-1:0] bank_rd;              // active bank, registered
  logic                       bus_wr;               // bus write commits this cycle
  logic                       wr_go;                // some write commits this cycle
  logic [4:0]                 wr_idx;               // index being written
  logic [31:0]                wr_data;              // data being written
  logic [3:0]                 wr_strb;              // strobes being written

  // an address is mapped when word aligned and inside the table
  function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a[ADDR_W-1:2] <= {1'b0, IDX_PAIR_A});
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] be);
    return {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  // view of one banked register out of the registered bank
  function automatic logic [15:0] bank_word(input logic [DATA_W*NBANKREG-1:0] b, input int i);
    return b[DATA_W*i +: DATA_W];
  endfunction

  // all next-state logic
  always_comb begin
    s_d       = s_q;
    mem_wen   = '0;
    mem_wbe   = '0;
    mem_wdata = '0;
    wr_go     = 1'b0;
    wr_idx    = 5'h00;
    wr_data   = 32'h00000000;
    wr_strb   = 4'h0;

    // address and data may arrive in either order; each is held until both are here
    if (s_awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_awaddr;
    end
    if (s_wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_wdata;
      s_d.w_strb = s_wstrb;
    end
    if (s_q.bvalid && s_bready) begin
      s_d.bvalid = 1'b0;
    end
    // execution unit has the write port first; the bus write waits while core_wr_en is high
    bus_wr = s_q.aw_have && s_q.w_have && !s_q.bvalid && !core_wr_en;
    if (bus_wr) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = reg_mapped(s_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end

    // pick the write source
    if (core_wr_en) begin
      wr_go   = 1'b1;
      wr_idx  = core_wr_idx;
      wr_data = core_wr_data;
      wr_strb = core_wr_strb;
    end else if (bus_wr) begin
      wr_go   = reg_mapped(s_q.aw_addr);
      wr_idx  = s_q.aw_addr[6:2];
      wr_data = s_q.w_data;
      wr_strb = s_q.w_strb;
    end

    if (wr_go) begin
      // RULE1 RULE14 banked copies
      if (wr_idx <= IDX_FRM) begin
        // RULE2 independent byte halves
        mem_wen[wr_idx[2:0]]              = 1'b1;
        mem_wbe[2*wr_idx[2:0] +: 2]       = wr_strb[1:0];
        mem_wdata[DATA_W*wr_idx[2:0] +: DATA_W] = wr_data[15:0];
      end
      case (wr_idx)
        // RULE6 twenty-bit counter
        IDX_PC: begin
          s_d.pc[15:0] = merge16(s_q.pc[15:0], wr_data[15:0], wr_strb[1:0]);
          if (wr_strb[2])
            s_d.pc[19:16] = wr_data[19:16];
        end
        // RULE7 twenty-bit table base
        IDX_VTAB: begin
          s_d.vtab[15:0] = merge16(s_q.vtab[15:0], wr_data[15:0], wr_strb[1:0]);
          if (wr_strb[2])
            s_d.vtab[19:16] = wr_data[19:16];
        end
        // RULE18 single unbanked registers
        IDX_USTK: s_d.ustk = merge16(s_q.ustk, wr_data[15:0], wr_strb[1:0]);
        IDX_ISTK: s_d.istk = merge16(s_q.istk, wr_data[15:0], wr_strb[1:0]);
        // RULE5 static base
        IDX_STAT: s_d.stat = merge16(s_q.stat, wr_data[15:0], wr_strb[1:0]);
        // RULE10 RULE17 reserved bits never stored
        IDX_FLAG: s_d.flag = merge16(s_q.flag, wr_data[15:0], wr_strb[1:0]) & FLAG_IMPL_MASK;
        // RULE3 even pair
        IDX_PAIR_E: begin
          mem_wen = 7'h05;
          mem_wbe = {8'h00, wr_strb[3:2], 2'h0, wr_strb[1:0]};
          mem_wdata[DATA_W*0 +: DATA_W] = wr_data[15:0];
          mem_wdata[DATA_W*2 +: DATA_W] = wr_data[31:16];
        end
        // RULE3 odd pair
        IDX_PAIR_O: begin
          mem_wen = 7'h0A;
          mem_wbe = {6'h00, wr_strb[3:2], 2'h0, wr_strb[1:0], 2'h0};
          mem_wdata[DATA_W*1 +: DATA_W] = wr_data[15:0];
          mem_wdata[DATA_W*3 +: DATA_W] = wr_data[31:16];
        end
        // RULE4 address pair
        IDX_PAIR_A: begin
          mem_wen = 7'h30;
          mem_wbe = {2'h0, wr_strb[3:2], wr_strb[1:0], 8'h00};
          mem_wdata[DATA_W*4 +: DATA_W] = wr_data[15:0];
          mem_wdata[DATA_W*5 +: DATA_W] = wr_data[31:16];
        end
        default: ;                                    // banked, read-only or unmapped
      endcase
    end

    // hardware events come after writes so an event in the write cycle is kept
    if (alu_valid) begin
      // RULE11 carry capture
      s_d.flag[FLAG_C] = alu_carry;
      // RULE13 result flags
      s_d.flag[FLAG_Z] = (alu_result == 16'h0000);
      s_d.flag[FLAG_S] = alu_result[15];
      s_d.flag[FLAG_O] = alu_overflow;
    end
    if (ack_valid) begin
      // RULE15 interrupts off on entry
      s_d.flag[FLAG_I] = 1'b0;
      // RULE9 interrupt stack on entry
      if (ack_hw)
        s_d.flag[FLAG_U] = 1'b0;
      // RULE12 debug flag cleared
      if (ack_single_step)
        s_d.flag[FLAG_D] = 1'b0;
    end
    // RULE9 low software interrupts
    if (swint_exec && (swint_num < SWINT_SP_LIM))
      s_d.flag[FLAG_U] = 1'b0;

    // RULE8 stack pointer select
    s_d.sp = s_d.flag[FLAG_U] ? s_d.ustk : s_d.istk;
    // RULE12 single step after instruction
    s_d.step_req = instr_done && s_q.flag[FLAG_D];
    // RULE15 RULE16 enable and strict priority
    s_d.irq_acc = req_valid && s_q.flag[FLAG_I] && (req_prio > s_q.flag[FLAG_PRI_LO +: FLAG_PRI_W]);

    // read: address taken, data one cycle later, held until rready
    if (s_arvalid && s_q.arready) begin
      s_d.ar_pend = 1'b1;
      s_d.ar_addr = s_araddr;
    end
    if (s_q.ar_pend) begin
      s_d.ar_pend = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rresp   = reg_mapped(s_q.ar_addr) ? RESP_OKAY : RESP_SLVERR;
      s_d.rdata   = 32'h00000000;
      if (reg_mapped(s_q.ar_addr)) begin
        case (s_q.ar_addr[6:2])
          IDX_PC:     s_d.rdata = {12'h000, s_q.pc};
          IDX_VTAB:   s_d.rdata = {12'h000, s_q.vtab};
          IDX_USTK:   s_d.rdata = {16'h0000, s_q.ustk};
          IDX_ISTK:   s_d.rdata = {16'h0000, s_q.istk};
          IDX_STAT:   s_d.rdata = {16'h0000, s_q.stat};
          IDX_FLAG:   s_d.rdata = {16'h0000, s_q.flag};
          IDX_SP:     s_d.rdata = {16'h0000, s_q.sp};
          IDX_PAIR_E: s_d.rdata = {bank_word(bank_rd, 2), bank_word(bank_rd, 0)};
          IDX_PAIR_O: s_d.rdata = {bank_word(bank_rd, 3), bank_word(bank_rd, 1)};
          IDX_PAIR_A: s_d.rdata = {bank_word(bank_rd, 5), bank_word(bank_rd, 4)};
          default:    s_d.rdata = {16'h0000, bank_word(bank_rd, int'(s_q.ar_addr[4:2]))};
        endcase
      end
    end
    if (s_q.rvalid && s_rready) begin
      s_d.rvalid = 1'b0;
    end

    // readies are registered: open only while nothing of that kind is pending
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready  = !s_d.w_have && !s_d.bvalid;
    s_d.arready = !s_d.ar_pend && !s_d.rvalid;
  end

  // state register; every control bit starts cleared
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q      <= '0;
      s_q.pc   <= REG20_RST;
      s_q.vtab <= REG20_RST;
      s_q.flag <= FLAG_RST;
      s_q.ustk <= REG16_RST;
      s_q.istk <= REG16_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // banked registers; the flag's bank bit steers both ports
  crs_bank_mem #(
    .NREG (NBANKREG),
    .W    (DATA_W)
  ) u_bank (
    .clk     (clk),
    .rst     (rst),
    .bank_wr (s_q.flag[FLAG_B]),
    .wen     (mem_wen),
    .wbe     (mem_wbe),
    .wdata   (mem_wdata),
    .bank_rd (s_q.flag[FLAG_B]),
    .rdata   (bank_rd)
  );

  // outputs straight from flip-flops
  assign s_awready       = s_q.awready;
  assign s_wready        = s_q.wready;
  assign s_bvalid        = s_q.bvalid;
  assign s_bresp         = s_q.bresp;
  assign s_arready       = s_q.arready;
  assign s_rvalid        = s_q.rvalid;
  assign s_rdata         = s_q.rdata;
  assign s_rresp         = s_q.rresp;
  assign pc_out          = s_q.pc;
  assign vector_base_out = s_q.vtab;
  assign flag_out        = s_q.flag;
  assign active_sp_out   = s_q.sp;
  assign static_base_out = s_q.stat;
  assign frame_base_out  = bank_rd[DATA_W*6 +: DATA_W];
  assign data_pair_even  = {bank_rd[DATA_W*2 +: DATA_W], bank_rd[DATA_W*0 +: DATA_W]};
  assign data_pair_odd   = {bank_rd[DATA_W*3 +: DATA_W], bank_rd[DATA_W*1 +: DATA_W]};
  assign addr_pair       = {bank_rd[DATA_W*5 +: DATA_W], bank_rd[DATA_W*4 +: DATA_W]};
  assign single_step_req = s_q.step_req;
  assign irq_accept      = s_q.irq_acc;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_flag_reserved: assert property (flag_out == (flag_out & FLAG_IMPL_MASK))  // RULE17
    else $error("reserved flag bit set");
  a_sp_select: assert property (active_sp_out == (flag_out[FLAG_U] ? s_q.ustk : s_q.istk))  // RULE8
    else $error("active stack pointer mismatch");
  a_hw_stack_clear: assert property (ack_valid && ack_hw |=> !flag_out[FLAG_U])  // RULE9
    else $error("stack select kept after hardware ack");
  a_swint_stack: assert property (swint_exec && swint_num < SWINT_SP_LIM |=> !flag_out[FLAG_U])  // RULE9
    else $error("stack select kept after low soft interrupt");
  a_ien_clear: assert property (ack_valid |=> !flag_out[FLAG_I])  // RULE15
    else $error("interrupt enable kept after ack");
  a_step_raise: assert property (instr_done && flag_out[FLAG_D] |=> single_step_req)  // RULE12
    else $error("single step not raised");
  a_debug_clear: assert property (ack_valid && ack_single_step |=> !flag_out[FLAG_D])  // RULE12
    else $error("debug flag kept after single step ack");
  a_prio_gate: assert property (irq_accept |-> $past(req_prio) > $past(flag_out[14:12])  // RULE16
    && $past(flag_out[FLAG_I]) && $past(req_valid)) else $error("request accepted without priority");
  a_zero_carry: assert property (alu_valid |=> flag_out[FLAG_Z] == ($past(alu_result) == 16'h0000)  // RULE13
    && flag_out[FLAG_C] == $past(alu_carry) && flag_out[FLAG_S] == $past(alu_result[15])
    && flag_out[FLAG_O] == $past(alu_overflow)) else $error("result flags wrong");
endmodule // crs_top
`default_nettype wire

// >>> hw/crs_pkg.sv
// Behaviour
// RULE1: thirteen registers; seven of them banked twice
// RULE2: data registers 16 bits; first two byte-split
// RULE3: data two/zero and three/one form pairs
// RULE4: address registers pair, one high zero low
// RULE5: frame base and static base 16 bits
// RULE6: program counter is 20 bits
// RULE7: vector table base is 20 bits
// RULE8: flag bit 7 selects user or interrupt stack
// RULE9: stack select clears on interrupt entry; code clears it only on hardware acks and low soft interrupts
// RULE10: flag word holds eleven implemented bits
// RULE11: flag bit 0 captures alu carry
// RULE12: debug flag raises single step, ack clears
// RULE13: zero, sign, overflow flags follow result
// RULE14: flag bit 4 selects register bank
// RULE15: flag bit 6 gates interrupts, ack clears
// RULE16: priority level bits 12-14 gate requests
// RULE17: flag bits 8-11 and 15 reserved
// RULE18: remaining registers are single, unbanked
`default_nettype none
package crs_pkg;
  localparam int DATA_W   = 16;              // data register width
  localparam int PC_W     = 20;              // program counter width
  localparam int NBANKREG = 7;               // banked registers per bank
  localparam int ADDR_W   = 8;               // bus address width
  // register word indices (byte address = index * 4)
  localparam logic [4:0] IDX_DATA0  = 5'h00;
  localparam logic [4:0] IDX_DATA1  = 5'h01;
  localparam logic [4:0] IDX_DATA2  = 5'h02;
  localparam logic [4:0] IDX_DATA3  = 5'h03;
  localparam logic [4:0] IDX_ADDR0  = 5'h04;
  localparam logic [4:0] IDX_ADDR1  = 5'h05;
  localparam logic [4:0] IDX_FRM    = 5'h06;
  localparam logic [4:0] IDX_PC     = 5'h07;
  localparam logic [4:0] IDX_VTAB   = 5'h08;
  localparam logic [4:0] IDX_USTK   = 5'h09;
  localparam logic [4:0] IDX_ISTK   = 5'h0A;
  localparam logic [4:0] IDX_STAT   = 5'h0B;
  localparam logic [4:0] IDX_FLAG   = 5'h0C;
  localparam logic [4:0] IDX_SP     = 5'h0D;
  localparam logic [4:0] IDX_PAIR_E = 5'h0E;
  localparam logic [4:0] IDX_PAIR_O = 5'h0F;
  localparam logic [4:0] IDX_PAIR_A = 5'h10;
  // flag word bit positions
  localparam int FLAG_C      = 0;
  localparam int FLAG_D      = 1;
  localparam int FLAG_Z      = 2;
  localparam int FLAG_S      = 3;
  localparam int FLAG_B      = 4;
  localparam int FLAG_O      = 5;
  localparam int FLAG_I      = 6;
  localparam int FLAG_U      = 7;
  localparam int FLAG_PRI_LO = 12;
  localparam int FLAG_PRI_W  = 3;
  localparam logic [15:0] FLAG_IMPL_MASK = 16'h70FF;   // implemented flag bits
  localparam logic [15:0] FLAG_RST       = 16'h0000;   // flag word after reset
  localparam logic [15:0] REG16_RST      = 16'h0000;   // 16-bit registers after reset
  localparam logic [19:0] REG20_RST      = 20'h00000;  // 20-bit registers after reset
  localparam logic [5:0]  SWINT_SP_LIM   = 6'h20;      // soft interrupts below this clear stack select
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage
`default_nettype wire

// >>> hw/crs_bank_mem.sv
`default_nettype none
module crs_bank_mem import crs_pkg::*; #(
  parameter int NREG = NBANKREG,                        // registers per bank
  parameter int W    = DATA_W                           // register width, two bytes
) (
  input  wire logic              clk,                   // core clock
  input  wire logic              rst,                   // async reset, active high
  input  wire logic              bank_wr,               // bank that writes go to
  input  wire logic [NREG-1:0]   wen,                   // per-register write enable
  input  wire logic [2*NREG-1:0] wbe,                   // per-byte enable, low byte first
  input  wire logic [W*NREG-1:0] wdata,                 // write data, register 0 lowest
  input  wire logic              bank_rd,               // bank shown on rdata
  output logic      [W*NREG-1:0] rdata                  // registered view of read bank
);
  typedef struct packed {
    logic [1:0][NREG-1:0][W-1:0] store;                 // both banks
    logic [NREG-1:0][W-1:0]      rd;                    // read register
  } crs_mem_t;
  crs_mem_t s_q, s_d;

  // byte merge per register; read follows the new contents so the lag is one cycle
  always_comb begin
    s_d = s_q;
    for (int r = 0; r < NREG; r++) begin
      if (wen[r] && wbe[2*r])
        s_d.store[bank_wr][r][7:0] = wdata[W*r +: 8];
      if (wen[r] && wbe[2*r+1])
        s_d.store[bank_wr][r][15:8] = wdata[W*r+8 +: 8];
    end
    s_d.rd = s_d.store[bank_rd];
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rd;
endmodule // crs_bank_mem
`default_nettype wire

// >>> testbench/crs_bench.sv
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, a, e); end end
module crs_bench import crs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // single-bit inputs other than rst start low so nothing is requested during reset
  logic clk = 1'b0, rst = 1'b1, s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0, core_wr_en = 1'b0, alu_valid = 1'b0, alu_carry = 1'b0;
  logic alu_overflow = 1'b0, instr_done = 1'b0, ack_valid = 1'b0, ack_hw = 1'b0, ack_single_step = 1'b0;
  logic swint_exec = 1'b0, req_valid = 1'b0, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [ADDR_W-1:0] s_awaddr = 8'h0, s_araddr = 8'h0;
  logic [2:0]  s_awprot = 3'h0, s_arprot = 3'h0, req_prio = 3'h0;
  logic [31:0] s_wdata = 32'h0, core_wr_data = 32'h0, s_rdata, data_pair_even, data_pair_odd, addr_pair;
  logic [3:0]  s_wstrb = 4'h0, core_wr_strb = 4'h0;
  logic [4:0]  core_wr_idx = 5'h0;
  logic [15:0] alu_result = 16'h0, flag_out, active_sp_out, static_base_out, frame_base_out;
  logic [5:0]  swint_num = 6'h0;
  logic [1:0]  s_bresp, s_rresp;
  logic [19:0] pc_out, vector_base_out;
  logic        single_step_req, irq_accept;
  int          n_mismatch = 0;   // mismatches seen
  int          tests_run = 0;    // comparisons made
  crs_top dut (.*);
  // free-running core clock, 4 ns period
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                    input logic [1:0] er = RESP_OKAY);
    int i;
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= s;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) break;
    end
    s_bready <= 1'b0;
    if (i == 64) begin n_mismatch++; print_verdict(); end
    `CHK(s_bresp, er)
  endtask
  // one read, compared against the expected word and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    int i;
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) break;
    end
    s_rready <= 1'b0;
    if (i == 64) begin n_mismatch++; print_verdict(); end
    `CHK(s_rdata, e)
    `CHK(s_rresp, er)
  endtask
  // main sequence: each call pairs a stimulus with the value the rules predict
  initial begin
    tk(6);
    rst <= 1'b0;
    tk(2);
    rd(8'h30, 32'h0);
    wr(8'h00, 32'h1234);
    wr(8'h30, 32'h10);
    wr(8'h00, 32'hABCD);
    rd(8'h00, 32'hABCD);
    wr(8'h30, 32'h0);
    rd(8'h00, 32'h1234);
    wr(8'h04, 32'hBBEE, 4'h1);
    rd(8'h04, 32'hEE);
    wr(8'h08, 32'h5678);
    rd(8'h38, 32'h56781234);
    `CHK(data_pair_even, 32'h56781234)
    wr(8'h3C, 32'h99998888);
    rd(8'h0C, 32'h9999);
    `CHK(data_pair_odd, 32'h99998888)
    wr(8'h10, 32'h1111);
    wr(8'h14, 32'h2222);
    rd(8'h40, 32'h22221111);
    `CHK(addr_pair, 32'h22221111)
    wr(8'h18, 32'hFFFFFFFF);
    rd(8'h18, 32'hFFFF);
    `CHK(frame_base_out, 16'hFFFF)
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, 32'hFFFFF);
    `CHK(pc_out, 20'hFFFFF)
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'hFFFFF);
    `CHK(vector_base_out, 20'hFFFFF)
    wr(8'h24, 32'hAAAA);
    wr(8'h28, 32'h5555);
    rd(8'h34, 32'h5555);
    `CHK(active_sp_out, 16'h5555)
    wr(8'h30, 32'h80);
    rd(8'h34, 32'hAAAA);
    `CHK(active_sp_out, 16'hAAAA)
    wr(8'h30, 32'hFFFF);
    rd(8'h30, 32'h70FF);
    rd(8'h1C, 32'hFFFFF);
    `CHK(pc_out, 20'hFFFFF)
    rd(8'h18, 32'h0);
    `CHK(frame_base_out, 16'h0000)
    // hardware plus single-step acknowledge drops enable, stack and debug bits
    {ack_valid, ack_hw, ack_single_step} <= 3'h7;
    tk(1);
    {ack_valid, ack_hw, ack_single_step} <= 3'h0;
    rd(8'h30, 32'h703D);
    `CHK(flag_out, 16'h703D)
    {alu_valid, alu_carry, alu_overflow} <= 3'h6;
    tk(1);
    alu_valid <= 1'b0;
    rd(8'h30, 32'h7015);
    {alu_valid, alu_carry, alu_overflow} <= 3'h5;
    alu_result <= 16'h8000;
    tk(1);
    alu_valid <= 1'b0;
    rd(8'h30, 32'h7038);
    wr(8'h30, 32'h3040);
    req_valid <= 1'b1;
    req_prio <= 3'h4;
    tk(2);
    `CHK(irq_accept, 1'b1)
    req_prio <= 3'h3;
    tk(2);
    `CHK(irq_accept, 1'b0)
    wr(8'h30, 32'h2);
    instr_done <= 1'b1;
    tk(1);
    instr_done <= 1'b0;
    tk(1);
    `CHK(single_step_req, 1'b1)
    wr(8'h30, 32'h80);
    swint_num <= 6'h20;
    swint_exec <= 1'b1;
    tk(1);
    swint_exec <= 1'b0;
    rd(8'h30, 32'h80);
    swint_num <= 6'h1F;
    swint_exec <= 1'b1;
    tk(1);
    swint_exec <= 1'b0;
    rd(8'h30, 32'h0);
    {core_wr_idx, core_wr_data, core_wr_strb, core_wr_en} <= {IDX_STAT, 32'h4321, 4'hF, 1'b1};
    tk(1);
    core_wr_en <= 1'b0;
    rd(8'h2C, 32'h4321);
    `CHK(static_base_out, 16'h4321)
    wr(8'h44, 32'h1, 4'hF, RESP_SLVERR);
    rd(8'h44, 32'h0, RESP_SLVERR);
    print_verdict();
  end
endmodule // crs_bench
`default_nettype wire
